// file: hdl/vtp_pkg.sv
// Constants, types and register map of the video test pattern control.
// Assumes one pixel clock domain shared with the video timing inputs.
package vtp_pkg;

  // ---------------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_LOOP = 8'h63;
  localparam logic [7:0] IDX_CTL = 8'h64;
  localparam logic [7:0] IDX_CFG = 8'h65;
  localparam logic [7:0] IDX_RED = 8'h70;
  localparam logic [7:0] IDX_GRN = 8'h71;
  localparam logic [7:0] IDX_BLU = 8'h72;
  localparam logic [7:0] IDX_FTIME = 8'h73;
  localparam logic [7:0] IDX_STAT = 8'h74;

  // ---------------------------------------------------------------------
  // Reset values and field positions.
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_LOOP = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h10;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_FTIME = 8'h1e;
  localparam logic [7:0] CFG_WMASK = 8'h1f;
  localparam int BIT_PWDN = 0;
  localparam int BIT_INV = 1;
  localparam int BIT_ASCRL = 0;

  // ---------------------------------------------------------------------
  // Ramp arithmetic: 256 levels spread over the measured active span.
  // ---------------------------------------------------------------------
  localparam logic [16:0] RAMP_STEP = 17'h00100;
  localparam logic [7:0] LEV_MAX = 8'hff;
  localparam logic [7:0] LEV_MIN = 8'h00;

  // Fixed pattern select codes.
  typedef enum logic [3:0] {
    SEL_RSV_LO = 4'b0000,
    SEL_WHITE = 4'b0001,
    SEL_CUSTOM = 4'b1110,
    SEL_RSV_HI = 4'b1111
  } vtp_sel_t;

  // Pattern source after priority resolution.
  typedef enum logic [1:0] {
    SRC_FIXED = 2'b00,
    SRC_BARS = 2'b01,
    SRC_COMPL = 2'b10,
    SRC_OFF = 2'b11
  } vtp_src_t;

  // Pattern control register layout.
  typedef struct packed {
    logic [3:0] sel;
    logic compl;
    logic bars;
    logic bandRev;
    logic genOn;
  } vtp_ctl_t;

  // One pixel of colour.
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vtp_rgb_t;

endpackage

// file: hdl/vtp_top.sv
// Register slave and pattern selection for the video test pattern block.
// Assumes clk is the pixel clock and vidDe/vidVsync come from same-clock
// timing logic, so they pass no synchroniser.
`timescale 1ns/100ps

module vtp_top
  import vtp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Video timing in
  input wire logic vidDe,
  input wire logic vidVsync,
  // Pattern out
  output vtp_rgb_t pixOut,
  output logic pixDe,
  output logic genActive,
  output logic loopDriverPowerdown
);

  // ---------------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------------
  logic [7:0] loopCtl_ff;
  vtp_ctl_t ctl_ff;
  logic [7:0] cfg_ff;
  logic [7:0] redLev_ff;
  logic [7:0] grnLev_ff;
  logic [7:0] bluLev_ff;
  logic [7:0] frameTime_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [7:0] idx;
  logic aligned;
  logic wrEn;
  logic rdSetup;
  logic hit;
  logic [31:0] nxt_rdata;
  vtp_src_t srcSel;
  logic [3:0] effSel;

  // Word decode: low address bits must be zero for an aligned word.
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wrEn = psel && penable && pwrite && ce && hit;
  assign rdSetup = psel && !penable && ce;
  assign pready = ce;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // Read mux; unmapped indices read zero and flag an error.
  always_comb
  begin
    hit = aligned;
    nxt_rdata = 32'h00000000;
    case (idx)
      IDX_LOOP: nxt_rdata[7:0] = loopCtl_ff;
      IDX_CTL: nxt_rdata[7:0] = ctl_ff;
      IDX_CFG: nxt_rdata[7:0] = cfg_ff;
      IDX_RED: nxt_rdata[7:0] = redLev_ff;
      IDX_GRN: nxt_rdata[7:0] = grnLev_ff;
      IDX_BLU: nxt_rdata[7:0] = bluLev_ff;
      IDX_FTIME: nxt_rdata[7:0] = frameTime_ff;
      IDX_STAT: nxt_rdata[7:0] = {1'b0, genActive, srcSel, effSel};
      default: hit = 1'b0;
    endcase
  end

  // Read data and error are set up in the setup cycle, held in access.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else if (rdSetup)
    begin
      prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
      pslverr_ff <= !hit;
    end
  end

  // Register writes take effect only at the access edge.
  // select resets to one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      loopCtl_ff <= RST_LOOP;
      ctl_ff <= RST_CTL;
      cfg_ff <= RST_CFG;
      redLev_ff <= RST_LEVEL;
      grnLev_ff <= RST_LEVEL;
      bluLev_ff <= RST_LEVEL;
      frameTime_ff <= RST_FTIME;
    end
    else if (wrEn)
    begin
      case (idx)
        IDX_LOOP: loopCtl_ff <= pwdata[7:0];
        IDX_CTL: ctl_ff <= pwdata[7:0];
        IDX_CFG: cfg_ff <= pwdata[7:0] & CFG_WMASK;
        IDX_RED: redLev_ff <= pwdata[7:0];
        IDX_GRN: grnLev_ff <= pwdata[7:0];
        IDX_BLU: bluLev_ff <= pwdata[7:0];
        IDX_FTIME: frameTime_ff <= pwdata[7:0];
        default: loopCtl_ff <= loopCtl_ff;
      endcase
    end
  end

  assign loopDriverPowerdown = loopCtl_ff[BIT_PWDN];
  assign genActive = ctl_ff.genOn;

  // ---------------------------------------------------------------------
  // Active span measurement and ramp levels
  // ---------------------------------------------------------------------
  logic dePrev_ff;
  logic vsPrev_ff;
  logic [11:0] pixCnt_ff;
  logic [11:0] lineCnt_ff;
  logic [11:0] width_ff;
  logic [11:0] height_ff;
  logic [16:0] hAcc_ff;
  logic [16:0] vAcc_ff;
  logic [7:0] hLev_ff;
  logic [7:0] vLev_ff;
  logic lineEnd;
  logic frameStart;
  logic [16:0] hSum;
  logic [16:0] vSum;

  assign lineEnd = dePrev_ff && !vidDe;
  assign frameStart = vidVsync && !vsPrev_ff;
  assign hSum = hAcc_ff + RAMP_STEP;
  assign vSum = vAcc_ff + RAMP_STEP;

  // Edge history of the timing inputs.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dePrev_ff <= 1'b0;
      vsPrev_ff <= 1'b0;
    end
    else if (ce)
    begin
      dePrev_ff <= vidDe;
      vsPrev_ff <= vidVsync;
    end
  end

  // Width and height of the previous line and frame steer the ramps, so
  // the first frame after a timing change shows a distorted ramp.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pixCnt_ff <= 12'h000;
      lineCnt_ff <= 12'h000;
      width_ff <= 12'h000;
      height_ff <= 12'h000;
    end
    else if (ce)
    begin
      pixCnt_ff <= vidDe ? pixCnt_ff + 12'h001 : 12'h000;
      if (lineEnd)
      begin
        width_ff <= pixCnt_ff;
      end
      if (frameStart)
      begin
        height_ff <= lineCnt_ff;
        lineCnt_ff <= 12'h000;
      end
      else if (lineEnd)
      begin
        lineCnt_ff <= lineCnt_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hAcc_ff <= 17'h00000;
      hLev_ff <= LEV_MIN;
    end
    else if (ce)
    begin
      if (!vidDe)
      begin
        hAcc_ff <= 17'h00000;
        hLev_ff <= LEV_MIN;
      end
      else if (hSum >= {5'h00, width_ff} && hLev_ff != LEV_MAX)
      begin
        hAcc_ff <= hSum - {5'h00, width_ff};
        hLev_ff <= hLev_ff + 8'h01;
      end
      else if (hLev_ff != LEV_MAX)
      begin
        hAcc_ff <= hSum;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      vAcc_ff <= 17'h00000;
      vLev_ff <= LEV_MIN;
    end
    else if (ce)
    begin
      if (frameStart)
      begin
        vAcc_ff <= 17'h00000;
        vLev_ff <= LEV_MIN;
      end
      else if (lineEnd && vLev_ff != LEV_MAX)
      begin
        if (vSum >= {5'h00, height_ff})
        begin
          vAcc_ff <= vSum - {5'h00, height_ff};
          vLev_ff <= vLev_ff + 8'h01;
        end
        else
        begin
          vAcc_ff <= vSum;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Auto scroll
  // ---------------------------------------------------------------------
  logic [3:0] scrollSel_ff;
  logic [7:0] frameCnt_ff;
  logic autoScroll;

  assign autoScroll = cfg_ff[BIT_ASCRL];

  // advance after the frame count, skipping reserved codes.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scrollSel_ff <= SEL_WHITE;
      frameCnt_ff <= 8'h00;
    end
    else if (ce)
    begin
      if (!autoScroll)
      begin
        scrollSel_ff <= ctl_ff.sel;
        frameCnt_ff <= 8'h00;
      end
      else if (frameStart)
      begin
        if (frameCnt_ff + 8'h01 >= frameTime_ff)
        begin
          frameCnt_ff <= 8'h00;
          scrollSel_ff <= (scrollSel_ff >= SEL_CUSTOM) ? SEL_WHITE
                          : scrollSel_ff + 4'h1;
        end
        else
        begin
          frameCnt_ff <= frameCnt_ff + 8'h01;
        end
      end
    end
  end

  assign effSel = autoScroll ? scrollSel_ff : ctl_ff.sel;

  // ---------------------------------------------------------------------
  // Pattern source and colour
  // ---------------------------------------------------------------------
  vtp_rgb_t raw;
  vtp_rgb_t pix_ff;
  logic de_ff;

  // Colour from an {r,g,b} mask and a level.
  function automatic vtp_rgb_t vtp_mask(input logic [2:0] m,
                                        input logic [7:0] l);
    vtp_mask = {m[2] ? l : 8'h00, m[1] ? l : 8'h00, m[0] ? l : 8'h00};
  endfunction

  always_comb
  begin
    if (!ctl_ff.genOn)
      srcSel = SRC_OFF;
    else if (ctl_ff.compl)
      srcSel = SRC_COMPL;
    else if (ctl_ff.bars)
      srcSel = SRC_BARS;
    else
      srcSel = SRC_FIXED;
  end

  // Colour for the current pixel of the chosen source.
  always_comb
  begin
    raw = '0;
    case (srcSel)
      SRC_COMPL:
      begin
        case ({vLev_ff[7], hLev_ff[7]})
          2'b00: raw = vtp_mask(ctl_ff.bandRev ? 3'b001 : 3'b110, LEV_MAX);
          2'b01: raw = vtp_mask(3'b011, LEV_MAX);
          2'b10: raw = vtp_mask(ctl_ff.bandRev ? 3'b110 : 3'b001, LEV_MAX);
          default: raw = vtp_mask(3'b100, LEV_MAX);
        endcase
      end
      SRC_BARS:
      begin
        case (hLev_ff[7:5])
          3'h0: raw = vtp_mask(3'b111, LEV_MAX);
          3'h1: raw = vtp_mask(3'b110, LEV_MAX);
          3'h2: raw = vtp_mask(3'b011, LEV_MAX);
          3'h3: raw = vtp_mask(3'b010, LEV_MAX);
          3'h4: raw = vtp_mask(3'b101, LEV_MAX);
          3'h5: raw = vtp_mask(3'b100, LEV_MAX);
          3'h6: raw = vtp_mask(3'b001, LEV_MAX);
          default: raw = vtp_mask(3'b000, LEV_MAX);
        endcase
      end
      SRC_FIXED:
      begin
        case (effSel)
          4'h1: raw = vtp_mask(3'b111, LEV_MAX);
          4'h2: raw = vtp_mask(3'b000, LEV_MAX);
          4'h3: raw = vtp_mask(3'b100, LEV_MAX);
          4'h4: raw = vtp_mask(3'b010, LEV_MAX);
          4'h5: raw = vtp_mask(3'b001, LEV_MAX);
          4'h6: raw = vtp_mask(3'b111, hLev_ff);
          4'h7: raw = vtp_mask(3'b100, hLev_ff);
          4'h8: raw = vtp_mask(3'b010, hLev_ff);
          4'h9: raw = vtp_mask(3'b001, hLev_ff);
          4'ha: raw = vtp_mask(3'b111, vLev_ff);
          4'hb: raw = vtp_mask(3'b100, vLev_ff);
          4'hc: raw = vtp_mask(3'b010, vLev_ff);
          4'hd: raw = vtp_mask(3'b001, vLev_ff);
          4'he: raw = {redLev_ff, grnLev_ff, bluLev_ff};
          // Reserved codes show black.
          default: raw = '0;
        endcase
      end
      default: raw = '0;
    endcase
  end

  // invert the whole output; an idle generator shows black.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pix_ff <= '0;
      de_ff <= 1'b0;
    end
    else if (ce)
    begin
      pix_ff <= (srcSel == SRC_OFF) ? '0
                : (cfg_ff[BIT_INV] ? ~raw : raw);
      de_ff <= vidDe;
    end
  end

  assign pixOut = pix_ff;
  assign pixDe = de_ff;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_pwdn_write: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && idx == IDX_LOOP |=> loopDriverPowerdown == $past(pwdata[0]))
    else $error("power down bit not taken");
  a_gen_switch: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && idx == IDX_CTL |=> genActive == $past(pwdata[0]))
    else $error("generator switch not taken");
  a_sel_reset: assert property (@(posedge clk)
    !rst_n |=> ctl_ff.sel == 4'h1)
    else $error("select field reset wrong");
  a_compl_first: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_ff.genOn && ctl_ff.compl |-> srcSel == SRC_COMPL)
    else $error("compliance not selected");
  a_bars_next: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_ff.genOn && !ctl_ff.compl && ctl_ff.bars |-> srcSel == SRC_BARS)
    else $error("bars priority wrong");
  a_scroll_sel: assert property (@(posedge clk) disable iff (!rst_n)
    autoScroll |-> effSel == scrollSel_ff)
    else $error("scroll not overriding select");
  a_scroll_hold: assert property (@(posedge clk) disable iff (!rst_n)
    autoScroll && !frameStart && ce |=> $stable(scrollSel_ff))
    else $error("scroll moved between frames");
  a_invert_out: assert property (@(posedge clk) disable iff (!rst_n)
    ce && srcSel != SRC_OFF && cfg_ff[BIT_INV] |=> pixOut == ~$past(raw))
    else $error("output not inverted");
  a_white_solid: assert property (@(posedge clk) disable iff (!rst_n)
    ce && srcSel == SRC_FIXED && effSel == 4'h1 && !cfg_ff[BIT_INV]
    |=> pixOut == 24'hffffff)
    else $error("white solid wrong");
  a_ramp_start: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !vidDe |=> hLev_ff == LEV_MIN)
    else $error("horizontal ramp not restarted");

  c_bars_on: cover property (@(posedge clk) srcSel == SRC_BARS && vidDe);
  c_scroll_step: cover property (@(posedge clk)
    autoScroll && frameStart ##1 $changed(scrollSel_ff));
  c_ramp_top: cover property (@(posedge clk) hLev_ff == LEV_MAX);

endmodule // vtp_top

// file: testbench/tb_video_test_pattern_control.sv
// Self-checking bench for the video test pattern control block.
// Assumes vtp_pkg and vtp_top are compiled first; the bench drives the
// APB port and the video timing inputs itself.
`timescale 1ns/100ps

module tb_video_test_pattern_control
  import vtp_pkg::*;
;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic clk, rst_n, ce, psel, penable, pwrite, vidDe, vidVsync;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, pixDe, genActive, loopDriverPowerdown, errv;
  vtp_rgb_t pixOut;
  vtp_rgb_t pix [0:255];
  int failures = 0;
  int nChecks = 0;
  localparam logic [23:0] BARS [0:7] = '{24'hffffff, 24'hffff00,
    24'h00ffff, 24'h00ff00, 24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};

  vtp_top u_vtp_top (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vidDe(vidDe),
    .vidVsync(vidVsync), .pixOut(pixOut), .pixDe(pixDe),
    .genActive(genActive), .loopDriverPowerdown(loopDriverPowerdown));

  // Free-running pixel clock, 8 ns period.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // -------------------------------------------------------------------
  // Compare and report
  // -------------------------------------------------------------------
  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkPix(string nm, vtp_rgb_t e, vtp_rgb_t g);
    nChecks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // APB master and register helpers
  // -------------------------------------------------------------------
  function automatic logic [11:0] adr(logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Optional stall drops ce in the access phase so pready is held low.
  task automatic apb(bit wr, logic [11:0] a, logic [31:0] wd, int stall);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    ce <= (stall == 0);
    forever
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
      n++;
      if (n >= stall)
        ce <= 1'b1;
      if (n > 100)
      begin
        failures++;
        break;
      end
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The register updates at the access edge; one more edge lets the new
  // value settle before a caller looks at the outputs it drives.
  task automatic regW(logic [11:0] a, logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 0);
    @(posedge clk);
  endtask

  task automatic regR(logic [11:0] a, logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0, 0);
    chk32(nm, e, rdv);
    chk32("slverr", 32'h0, {31'h0, errv});
  endtask

  task automatic ctlW(logic [3:0] s, bit c, bit b, bit r, bit on);
    regW(adr(IDX_CTL), {s, c, b, r, on});
  endtask

  // -------------------------------------------------------------------
  // Video stimulus and expected colours
  // -------------------------------------------------------------------
  // Pixel k is driven after one edge and shows on pixOut after the next.
  task automatic runLine(int w);
    for (int k = 0; k <= w; k++)
    begin
      @(posedge clk);
      vidDe <= (k < w);
      #1;
      if (k > 0)
        pix[k-1] = pixOut;
      if (k == 1)
        chk32("pixDe", 32'h1, {31'h0, pixDe});
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic vsyncPulse();
    @(posedge clk);
    vidVsync <= 1'b1;
    @(posedge clk);
    vidVsync <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Codes 1..9 are solid colours and horizontal ramps at level l.
  function automatic vtp_rgb_t expCol(int k, logic [7:0] l, bit inv);
    vtp_rgb_t c;
    case (k)
      1: c = 24'hffffff;
      2: c = 24'h000000;
      3: c = 24'hff0000;
      4: c = 24'h00ff00;
      5: c = 24'h0000ff;
      6: c = {l, l, l};
      7: c = {l, 16'h0};
      8: c = {8'h0, l, 8'h0};
      9: c = {16'h0, l};
      default: c = 24'h0;
    endcase
    return inv ? ~c : c;
  endfunction

  // Four-band colour: yellow, cyan, blue, red from top left; the reversed
  // order swaps the left column top to bottom.
  function automatic vtp_rgb_t expBand(bit bot, bit right, bit rev);
    bit b;
    b = (rev && !right) ? !bot : bot;
    case ({b, right})
      2'b00: return 24'hffff00;
      2'b01: return 24'h00ffff;
      2'b10: return 24'h0000ff;
      default: return 24'hff0000;
    endcase
  endfunction

  // Watchdog well beyond the ten thousand or so cycles the tests need.
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [7:0] lr, lg, lb;
    bit inv;
    bit rv;
    int sv;
    {ce, rst_n, psel, penable, pwrite, vidDe, vidVsync} = 7'b1000000;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(5724));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;

    // Reset values, decode errors and a stalled access.
    regR(adr(IDX_LOOP), 32'h0, "loop reset");
    regR(adr(IDX_CTL), {24'h0, RST_CTL}, "ctl reset");
    regR(adr(IDX_CFG), 32'h0, "cfg reset");
    regR(adr(IDX_FTIME), 32'h1e, "frame time reset");
    apb(1'b0, adr(IDX_CTL), 32'h0, 2);
    chk32("stalled read", {24'h0, RST_CTL}, rdv);
    apb(1'b0, 12'h000, 32'h0, 0);
    chk32("unmapped err", 32'h1, {31'h0, errv});
    apb(1'b0, 12'h191, 32'h0, 0);
    chk32("misaligned err", 32'h1, {31'h0, errv});
    apb(1'b1, 12'h58c, 32'h1, 0);
    regR(adr(IDX_LOOP), 32'h0, "alias write");
    $display("test reset done");

    // Loop driver power-down first, then generator enable.
    d = $urandom;
    regW(adr(IDX_LOOP), d[7:0]);
    regR(adr(IDX_LOOP), {24'h0, d[7:0]}, "loop rw");
    chk32("powerdown", {31'h0, d[0]}, {31'h0, loopDriverPowerdown});
    regW(adr(IDX_LOOP), 8'h01);
    chk32("powerdown", 32'h1, {31'h0, loopDriverPowerdown});
    d = $urandom;
    regW(adr(IDX_CFG), d[7:0]);
    regR(adr(IDX_CFG), {24'h0, d[7:0] & CFG_WMASK}, "cfg rw");
    regW(adr(IDX_CFG), 8'h00);
    ctlW(4'h1, 0, 0, 0, 1);
    chk32("gen on", 32'h1, {31'h0, genActive});
    $display("test enable done");

    // Solid colours in both polarities, reserved code 0, generator off.
    for (int s = 1; s <= 5; s++)
      for (int v = 0; v < 2; v++)
      begin
        regW(adr(IDX_CFG), {6'h0, v[0], 1'b0});
        ctlW(s[3:0], 0, 0, 0, 1);
        runLine(4);
        chkPix("solid", expCol(s, 8'h0, v[0]), pix[2]);
      end
    regW(adr(IDX_CFG), 8'h00);
    ctlW(4'h0, 0, 0, 0, 1);
    runLine(4);
    chkPix("reserved", 24'h0, pix[2]);
    ctlW(4'h1, 0, 0, 0, 0);
    chk32("gen off", 32'h0, {31'h0, genActive});
    runLine(4);
    chkPix("gen off", 24'h0, pix[2]);
    $display("test solid done");

    // Custom colour from random levels, random polarity.
    d = $urandom;
    {lr, lg, lb} = d[23:0];
    inv = d[24];
    regW(adr(IDX_RED), lr);
    regW(adr(IDX_GRN), lg);
    regW(adr(IDX_BLU), lb);
    regW(adr(IDX_CFG), {6'h0, inv, 1'b0});
    ctlW(4'he, 0, 0, 0, 1);
    runLine(4);
    chkPix("custom", inv ? ~{lr, lg, lb} : {lr, lg, lb}, pix[1]);
    regW(adr(IDX_CFG), 8'h00);
    $display("test custom done");

    // Horizontal ramps over a 256-pixel line; first line only measures.
    for (int s = 6; s <= 9; s++)
    begin
      ctlW(s[3:0], 0, 0, 0, 1);
      runLine(256);
      runLine(256);
      chkPix("ramp start", expCol(s, 8'h00, 0), pix[0]);
      chkPix("ramp mid", expCol(s, 8'd100, 0), pix[100]);
      chkPix("ramp end", expCol(s, 8'hff, 0), pix[255]);
    end
    $display("test ramp done");

    // Colour bars, eight bands of 32 pixels, then source priority.
    ctlW(4'h3, 0, 1, 0, 1);
    runLine(256);
    runLine(256);
    for (int b = 0; b < 8; b++)
      chkPix("bar", BARS[b], pix[16 + 32 * b]);
    for (int m = 0; m < 8; m++)
    begin
      ctlW(4'h3, m[2], m[1], 0, m[0]);
      apb(1'b0, adr(IDX_STAT), 32'h0, 0);
      d = {29'h0, m[0], !m[0] ? 2'd3 : m[2] ? 2'd2 : {1'b0, m[1]}};
      chk32("source", d, {29'h0, rdv[6:4]});
    end
    $display("test priority done");

    // Vertical ramp and compliance bands over 256-line frames; the first
    // frame only measures the height.
    d = $urandom;
    sv = 10 + d[1:0];
    rv = d[2];
    ctlW(sv[3:0], 0, 0, 0, 1);
    for (int f = 0; f < 2; f++)
    begin
      vsyncPulse();
      for (int j = 0; j < 256; j++)
      begin
        if (f == 1 && (j == 50 || j == 200))
        begin
          ctlW(sv[3:0], 1, 0, rv, 1);
          runLine(256);
          chkPix("band left", expBand(j > 127, 0, rv), pix[0]);
          chkPix("band right", expBand(j > 127, 1, rv), pix[255]);
          ctlW(sv[3:0], 0, 0, 0, 1);
        end
        else
        begin
          runLine(2);
          if (f == 1 && (j == 0 || j == 100 || j == 255))
            chkPix("vramp", expCol(sv - 4, j[7:0], 0), pix[0]);
        end
      end
    end
    $display("test vertical done");

    // Auto scroll with a one-frame period, wrap from 14 back to 1.
    regW(adr(IDX_FTIME), 8'h01);
    ctlW(4'hd, 0, 0, 0, 1);
    regW(adr(IDX_CFG), 8'h01);
    vsyncPulse();
    regR(adr(IDX_STAT), 32'h4e, "scroll step");
    vsyncPulse();
    regR(adr(IDX_STAT), 32'h41, "scroll wrap");
    ctlW(4'h5, 0, 0, 0, 1);
    regR(adr(IDX_STAT), 32'h41, "select ignored");
    runLine(4);
    chkPix("scroll white", expCol(1, 8'h0, 0), pix[2]);
    regW(adr(IDX_CFG), 8'h00);
    vsyncPulse();
    regR(adr(IDX_STAT), 32'h45, "scroll held");
    $display("test scroll done");
    final_report();
  end

endmodule // tb_video_test_pattern_control
